// [pfs_func_decode.sv]
// decoder from selection registers and operating mode to port A pin functions
// assumes registers hold only writable bits; reserved codes fall back to I/O

`timescale 1ns/1ps

module pfs_func_decode
	import pfs_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0
) (
	pfs_sel_if.decoder sel
);

	logic single;
	logic romInv;

	// bus strobe pins, full variant only (small variant always I/O): set bit unless single-chip, clear bit only when ROM invalid
	function automatic pfs_func_e strobeFn(input logic bitVal, input logic sc, input logic ri,
			input pfs_func_e fn);
		pfs_func_e r;
		r = PFS_FN_GPIO;
		if (SMALL_VARIANT) begin
			r = PFS_FN_GPIO;
		end else if (bitVal) begin
			r = sc ? PFS_FN_GPIO : fn;
		end else if (ri) begin
			r = fn;
		end
		return r;
	endfunction : strobeFn

	always_comb begin
		single = (sel.mode == PFS_MODE_SINGLE);
		romInv = (sel.mode == PFS_MODE_ROMINV);
		sel.func = '{default: PFS_FN_GPIO};

		sel.func[15] = sel.sel1[PFS_S1_PIN15] ? PFS_FN_CLKOUT : PFS_FN_GPIO;
		sel.func[14] = strobeFn(sel.sel1[PFS_S1_PIN14], single, romInv, PFS_FN_RD);
		sel.func[13] = strobeFn(sel.sel1[PFS_S1_PIN13], single, romInv, PFS_FN_WRH);
		sel.func[12] = strobeFn(sel.sel1[PFS_S1_PIN12], single, romInv, PFS_FN_WRL);
		sel.func[11] = strobeFn(sel.sel1[PFS_S1_PIN11], single, romInv, PFS_FN_CS1);
		sel.func[10] = strobeFn(sel.sel1[PFS_S1_PIN10], single, romInv, PFS_FN_CS0);

		unique case (sel.sel1[PFS_S1_PIN9 +: 2])
			PFS_FLD_ALT1: sel.func[9] = PFS_FN_TIMER_EXT_CLK_D;
			PFS_FLD_ALT2: sel.func[9] = PFS_FN_EXT_INT_REQ_3;
			default:      sel.func[9] = PFS_FN_GPIO;
		endcase
		unique case (sel.sel1[PFS_S1_PIN8 +: 2])
			PFS_FLD_ALT1: sel.func[8] = PFS_FN_TIMER_EXT_CLK_C;
			PFS_FLD_ALT2: sel.func[8] = PFS_FN_EXT_INT_REQ_2;
			default:      sel.func[8] = PFS_FN_GPIO;
		endcase
		unique case (sel.sel2[PFS_S2_PIN7 +: 2])
			PFS_FLD_ALT1: sel.func[7] = PFS_FN_TIMER_EXT_CLK_B;
			PFS_FLD_ALT2: sel.func[7] = single ? PFS_FN_GPIO : PFS_FN_CS3;
			default:      sel.func[7] = PFS_FN_GPIO;
		endcase
		unique case (sel.sel2[PFS_S2_PIN6 +: 2])
			PFS_FLD_ALT1: sel.func[6] = PFS_FN_TIMER_EXT_CLK_A;
			PFS_FLD_ALT2: sel.func[6] = single ? PFS_FN_GPIO : PFS_FN_CS2;
			default:      sel.func[6] = PFS_FN_GPIO;
		endcase
		unique case (sel.sel2[PFS_S2_PIN5 +: 2])
			PFS_FLD_ALT1: sel.func[5] = PFS_FN_SERIAL_CLOCK_1;
			PFS_FLD_ALT2: sel.func[5] = single ? PFS_FN_GPIO : PFS_FN_DMA_REQUEST_1;
			PFS_FLD_ALT3: sel.func[5] = PFS_FN_EXT_INT_REQ_1;
			default:      sel.func[5] = PFS_FN_GPIO;
		endcase
		sel.func[4] = sel.sel2[PFS_S2_PIN4] ? PFS_FN_TX1 : PFS_FN_GPIO;
		sel.func[3] = sel.sel2[PFS_S2_PIN3] ? PFS_FN_RX1 : PFS_FN_GPIO;
		unique case (sel.sel2[PFS_S2_PIN2 +: 2])
			PFS_FLD_ALT1: sel.func[2] = PFS_FN_SERIAL_CLOCK_0;
			PFS_FLD_ALT2: sel.func[2] = single ? PFS_FN_GPIO : PFS_FN_DMA_REQUEST_0;
			PFS_FLD_ALT3: sel.func[2] = PFS_FN_EXT_INT_REQ_0;
			default:      sel.func[2] = PFS_FN_GPIO;
		endcase
		sel.func[1] = sel.sel2[PFS_S2_PIN1] ? PFS_FN_TX0 : PFS_FN_GPIO;
		sel.func[0] = sel.sel2[PFS_S2_PIN0] ? PFS_FN_RX0 : PFS_FN_GPIO;
	end

endmodule : pfs_func_decode

// [pfs_pin_partner.sv]
// pad model of the boards behind ports A and B
// assumes a driven pin wins over the external level set by the bench

`timescale 1ns/1ps

module pfs_pin_partner (
	input wire logic [15:0] portaOut,
	input wire logic [15:0] portaOe,
	input wire logic [15:0] padA,
	input wire logic [9:0]  portbOut,
	input wire logic [9:0]  portbOe,
	input wire logic [9:0]  padB,
	output logic     [15:0] portaIn,
	output logic     [9:0]  portbIn
);
	assign portaIn = (portaOe & portaOut) | (~portaOe & padA);
	assign portbIn = (portbOe & portbOut) | (~portbOe & padB);
endmodule : pfs_pin_partner

// [pfs_pkg.sv]
// constants and types for the port A/B pin function select block
// assumes a 16-bit register port and a 100 MHz ref_clk with synchronous reset

package pfs_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, 16-bit registers)
	// ----------------------------------------------------------------
	localparam logic [31:0] PFS_ADDR_PA_DATA  = 32'hFFFF_8382;
	localparam logic [31:0] PFS_ADDR_PA_DIR   = 32'hFFFF_8386;
	localparam logic [31:0] PFS_ADDR_SEL1     = 32'hFFFF_838C;
	localparam logic [31:0] PFS_ADDR_SEL2     = 32'hFFFF_838E;
	localparam logic [31:0] PFS_ADDR_PB_DATA  = 32'hFFFF_8390;
	localparam logic [31:0] PFS_ADDR_PB_DIR   = 32'hFFFF_8394;

	// writable bits; everything else reads as zero
	localparam logic [15:0] PFS_SEL1_MASK       = 16'h555F;
	localparam logic [15:0] PFS_SEL1_MASK_SMALL = 16'h400F;
	localparam logic [15:0] PFS_SEL2_MASK       = 16'hFD75;
	localparam logic [15:0] PFS_PB_MASK         = 16'h03FF;
	localparam logic [15:0] PFS_RESET_WORD      = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PFS_S1_PIN15 = 14;
	localparam int PFS_S1_PIN14 = 12;
	localparam int PFS_S1_PIN13 = 10;
	localparam int PFS_S1_PIN12 = 8;
	localparam int PFS_S1_PIN11 = 6;
	localparam int PFS_S1_PIN10 = 4;
	localparam int PFS_S1_PIN9  = 2;
	localparam int PFS_S1_PIN8  = 0;
	localparam int PFS_S2_PIN7  = 14;
	localparam int PFS_S2_PIN6  = 12;
	localparam int PFS_S2_PIN5  = 10;
	localparam int PFS_S2_PIN4  = 8;
	localparam int PFS_S2_PIN3  = 6;
	localparam int PFS_S2_PIN2  = 4;
	localparam int PFS_S2_PIN1  = 2;
	localparam int PFS_S2_PIN0  = 0;

	// two-bit field codes
	localparam logic [1:0] PFS_FLD_ALT1 = 2'h1;
	localparam logic [1:0] PFS_FLD_ALT2 = 2'h2;
	localparam logic [1:0] PFS_FLD_ALT3 = 2'h3;

	// mode strap codes
	localparam logic [1:0] PFS_STRAP_SINGLE = 2'h0;
	localparam logic [1:0] PFS_STRAP_ROMINV = 2'h2;

	localparam int PFS_PA_PINS = 16;
	localparam int PFS_PB_PINS = 10;

	typedef enum logic [1:0] {
		PFS_MODE_SINGLE,
		PFS_MODE_EXT,
		PFS_MODE_ROMINV
	} pfs_mode_e;

	typedef enum logic [4:0] {
		PFS_FN_GPIO,
		PFS_FN_CLKOUT,
		PFS_FN_RD,
		PFS_FN_WRH,
		PFS_FN_WRL,
		PFS_FN_CS0,
		PFS_FN_CS1,
		PFS_FN_CS2,
		PFS_FN_CS3,
		PFS_FN_TIMER_EXT_CLK_A,
		PFS_FN_TIMER_EXT_CLK_B,
		PFS_FN_TIMER_EXT_CLK_C,
		PFS_FN_TIMER_EXT_CLK_D,
		PFS_FN_EXT_INT_REQ_0,
		PFS_FN_EXT_INT_REQ_1,
		PFS_FN_EXT_INT_REQ_2,
		PFS_FN_EXT_INT_REQ_3,
		PFS_FN_SERIAL_CLOCK_0,
		PFS_FN_SERIAL_CLOCK_1,
		PFS_FN_DMA_REQUEST_0,
		PFS_FN_DMA_REQUEST_1,
		PFS_FN_TX0,
		PFS_FN_TX1,
		PFS_FN_RX0,
		PFS_FN_RX1
	} pfs_func_e;

endpackage : pfs_pkg

// [pfs_port_select.sv]
// top of the port A/B pin function select block: registers, pin muxing,
// routing of selected pin inputs to peripherals
// assumes pins and mode straps are asynchronous; peripheral signals share ref_clk

`timescale 1ns/1ps

module pfs_port_select
	import pfs_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [31:0] busAddr,
	input  wire logic [15:0] busWrData,
	input  wire logic        busWr,
	input  wire logic        busRd,
	output logic      [15:0] busRdData,
	// operating mode strap
	input  wire logic [1:0]  modeStrap,
	// port A pins
	input  wire logic [15:0] portaIn,
	output logic      [15:0] portaOut,
	output logic      [15:0] portaOe,
	// port B pins
	input  wire logic [9:0]  portbIn,
	output logic      [9:0]  portbOut,
	output logic      [9:0]  portbOe,
	// from bus controller and serial channels
	input  wire logic        sysClkOutSrc,
	input  wire logic        readStrobeN,
	input  wire logic        writeStrobeHighN,
	input  wire logic        writeStrobeLowN,
	input  wire logic [3:0]  chipSelN,
	input  wire logic [1:0]  serialTx,
	input  wire logic [1:0]  serialClockOut,
	input  wire logic [1:0]  serialClockDrive,
	// to timer, serial channels, DMA and interrupt controller
	output logic      [3:0]  timerExtClk,
	output logic      [3:0]  extIntReqN,
	output logic      [1:0]  dmaRequestN,
	output logic      [1:0]  serialRx,
	output logic      [1:0]  serialClockIn
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] sel1;
		logic [15:0] sel2;
		logic [15:0] paDir;
		logic [15:0] paData;
		logic [15:0] pbDir;
		logic [15:0] pbData;
		pfs_mode_e   mode;
		logic [15:0] paMeta;
		logic [15:0] paSync;
		logic [9:0]  pbMeta;
		logic [9:0]  pbSync;
		logic [1:0]  modeMeta;
		logic [1:0]  modeSync;
		logic [15:0] paOut;
		logic [15:0] paOe;
		logic [9:0]  pbOut;
		logic [9:0]  pbOe;
		logic [15:0] rdData;
		logic [3:0]  tclk;
		logic [3:0]  irqN;
		logic [1:0]  dreqN;
		logic [1:0]  rx;
		logic [1:0]  sckIn;
	} pfs_state_s;

	pfs_state_s state_reg;
	pfs_state_s state_next;

	pfs_sel_if  selBus ();

	logic [15:0] pinOut;
	logic [15:0] pinOe;
	logic [15:0] sel1Mask;
	pfs_mode_e   strapMode;

	assign selBus.sel1 = state_reg.sel1;
	assign selBus.sel2 = state_reg.sel2;
	assign selBus.mode = state_reg.mode;

	pfs_func_decode #(
		.SMALL_VARIANT (SMALL_VARIANT)
	) funcDecode (
		.sel (selBus.decoder)
	);

	// ----------------------------------------------------------------
	// per-pin output muxing for port A
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PFS_PA_PINS; gi++) begin : gPin
			always_comb begin
				pinOut[gi] = 1'b0;
				pinOe[gi]  = 1'b0;
				unique case (selBus.func[gi])
					PFS_FN_GPIO: begin
						pinOut[gi] = state_reg.paData[gi];
						pinOe[gi]  = state_reg.paDir[gi];
					end
					PFS_FN_CLKOUT: begin
						pinOut[gi] = sysClkOutSrc;
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_RD: begin
						pinOut[gi] = readStrobeN;
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_WRH: begin
						pinOut[gi] = writeStrobeHighN;
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_WRL: begin
						pinOut[gi] = writeStrobeLowN;
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_CS0: begin
						pinOut[gi] = chipSelN[0];
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_CS1: begin
						pinOut[gi] = chipSelN[1];
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_CS2: begin
						pinOut[gi] = chipSelN[2];
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_CS3: begin
						pinOut[gi] = chipSelN[3];
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_TX0: begin
						pinOut[gi] = serialTx[0];
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_TX1: begin
						pinOut[gi] = serialTx[1];
						pinOe[gi]  = 1'b1;
					end
					PFS_FN_SERIAL_CLOCK_0: begin
						// clock direction belongs to the serial channel
						pinOut[gi] = serialClockOut[0];
						pinOe[gi]  = serialClockDrive[0];
					end
					PFS_FN_SERIAL_CLOCK_1: begin
						pinOut[gi] = serialClockOut[1];
						pinOe[gi]  = serialClockDrive[1];
					end
					default: begin
						// input functions leave the pin undriven
						pinOut[gi] = 1'b0;
						pinOe[gi]  = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		sel1Mask   = SMALL_VARIANT ? PFS_SEL1_MASK_SMALL : PFS_SEL1_MASK;

		unique case (state_reg.modeSync)
			PFS_STRAP_SINGLE: strapMode = PFS_MODE_SINGLE;
			PFS_STRAP_ROMINV: strapMode = PFS_MODE_ROMINV;
			default:          strapMode = PFS_MODE_EXT;
		endcase

		// synchronisers: first stage feeds only the second
		state_next.paMeta   = portaIn;
		state_next.paSync   = state_reg.paMeta;
		state_next.pbMeta   = portbIn;
		state_next.pbSync   = state_reg.pbMeta;
		state_next.modeMeta = modeStrap;
		state_next.modeSync = state_reg.modeMeta;

		// register writes
		if (busWr) begin
			unique case (busAddr)
				PFS_ADDR_SEL1:    state_next.sel1   = busWrData & sel1Mask;
				PFS_ADDR_SEL2:    state_next.sel2   = busWrData & PFS_SEL2_MASK;
				PFS_ADDR_PA_DIR:  state_next.paDir  = busWrData;
				PFS_ADDR_PA_DATA: state_next.paData = busWrData;
				PFS_ADDR_PB_DIR:  state_next.pbDir  = busWrData & PFS_PB_MASK;
				PFS_ADDR_PB_DATA: state_next.pbData = busWrData & PFS_PB_MASK;
				default: ;
			endcase
		end

		// register reads, answered one cycle later; data registers show
		// the pin level for inputs and the latch for outputs
		state_next.rdData = PFS_RESET_WORD;
		if (busRd) begin
			unique case (busAddr)
				PFS_ADDR_SEL1:    state_next.rdData = state_reg.sel1;
				PFS_ADDR_SEL2:    state_next.rdData = state_reg.sel2;
				PFS_ADDR_PA_DIR:  state_next.rdData = state_reg.paDir;
				PFS_ADDR_PA_DATA: state_next.rdData = (state_reg.paDir & state_reg.paData)
					| (~state_reg.paDir & state_reg.paSync);
				PFS_ADDR_PB_DIR:  state_next.rdData = state_reg.pbDir;
				PFS_ADDR_PB_DATA: state_next.rdData = (state_reg.pbDir & state_reg.pbData)
					| (~state_reg.pbDir & {6'h00, state_reg.pbSync});
				default:          state_next.rdData = PFS_RESET_WORD;
			endcase
		end

		// pin drivers, registered so every output leaves a flop
		state_next.paOut = pinOut;
		state_next.paOe  = pinOe;
		state_next.pbOut = state_reg.pbData[PFS_PB_PINS-1:0];
		state_next.pbOe  = state_reg.pbDir[PFS_PB_PINS-1:0];

		// selected pin inputs to peripherals; deselected ones sit idle
		state_next.tclk[0]  = (selBus.func[6] == PFS_FN_TIMER_EXT_CLK_A) & state_reg.paSync[6];
		state_next.tclk[1]  = (selBus.func[7] == PFS_FN_TIMER_EXT_CLK_B) & state_reg.paSync[7];
		state_next.tclk[2]  = (selBus.func[8] == PFS_FN_TIMER_EXT_CLK_C) & state_reg.paSync[8];
		state_next.tclk[3]  = (selBus.func[9] == PFS_FN_TIMER_EXT_CLK_D) & state_reg.paSync[9];
		state_next.irqN[0]  = (selBus.func[2] == PFS_FN_EXT_INT_REQ_0) ? state_reg.paSync[2] : 1'b1;
		state_next.irqN[1]  = (selBus.func[5] == PFS_FN_EXT_INT_REQ_1) ? state_reg.paSync[5] : 1'b1;
		state_next.irqN[2]  = (selBus.func[8] == PFS_FN_EXT_INT_REQ_2) ? state_reg.paSync[8] : 1'b1;
		state_next.irqN[3]  = (selBus.func[9] == PFS_FN_EXT_INT_REQ_3) ? state_reg.paSync[9] : 1'b1;
		state_next.dreqN[0] = (selBus.func[2] == PFS_FN_DMA_REQUEST_0) ? state_reg.paSync[2] : 1'b1;
		state_next.dreqN[1] = (selBus.func[5] == PFS_FN_DMA_REQUEST_1) ? state_reg.paSync[5] : 1'b1;
		state_next.rx[0]    = (selBus.func[0] == PFS_FN_RX0) ? state_reg.paSync[0] : 1'b1;
		state_next.rx[1]    = (selBus.func[3] == PFS_FN_RX1) ? state_reg.paSync[3] : 1'b1;
		state_next.sckIn[0] = (selBus.func[2] == PFS_FN_SERIAL_CLOCK_0) & state_reg.paSync[2];
		state_next.sckIn[1] = (selBus.func[5] == PFS_FN_SERIAL_CLOCK_1) & state_reg.paSync[5];

		// reset: mode is caught from the synchronised strap while reset is held,
		// so reset must outlast the synchroniser
		if (rst) begin
			state_next.mode   = strapMode;
			state_next.sel1   = PFS_RESET_WORD;
			state_next.sel1[PFS_S1_PIN15] = (strapMode != PFS_MODE_SINGLE);
			state_next.sel2   = PFS_RESET_WORD;
			state_next.paDir  = PFS_RESET_WORD;
			state_next.paData = PFS_RESET_WORD;
			state_next.pbDir  = PFS_RESET_WORD;
			state_next.pbData = PFS_RESET_WORD;
			state_next.rdData = PFS_RESET_WORD;
			state_next.paOut  = '0;
			state_next.paOe   = '0;
			state_next.pbOut  = '0;
			state_next.pbOe   = '0;
			state_next.tclk   = '0;
			state_next.irqN   = '1;
			state_next.dreqN  = '1;
			state_next.rx     = '1;
			state_next.sckIn  = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign busRdData     = state_reg.rdData;
	assign portaOut      = state_reg.paOut;
	assign portaOe       = state_reg.paOe;
	assign portbOut      = state_reg.pbOut;
	assign portbOe       = state_reg.pbOe;
	assign timerExtClk   = state_reg.tclk;
	assign extIntReqN    = state_reg.irqN;
	assign dmaRequestN   = state_reg.dreqN;
	assign serialRx      = state_reg.rx;
	assign serialClockIn = state_reg.sckIn;

endmodule : pfs_port_select

// [pfs_port_select_bench.sv]
// self-checking bench for the port A/B pin function select block
// assumes the checker is bound in and the pin partner resolves pad levels

`timescale 1ns/1ps

module pfs_port_select_bench
	import pfs_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst, busWr, busRd, sysClkOutSrc, readStrobeN, writeStrobeHighN, writeStrobeLowN;
	logic [31:0] busAddr;
	logic [15:0] busWrData, padA;
	logic [9:0]  padB;
	logic [3:0]  chipSelN;
	logic [1:0]  modeStrap, serialTx, serialClockOut, serialClockDrive;
	wire  [15:0] busRdData, portaIn, portaOut, portaOe, smallOe;
	wire  [9:0]  portbIn, portbOut, portbOe;
	wire  [3:0]  timerExtClk, extIntReqN;
	wire  [1:0]  dmaRequestN, serialRx, serialClockIn;
	int          n_mismatch = 0;
	int          n_checks = 0;

	always #5 ref_clk = ~ref_clk;

	pfs_port_select dut (.ref_clk, .rst, .busAddr, .busWrData, .busWr, .busRd, .busRdData, .modeStrap,
		.portaIn, .portaOut, .portaOe, .portbIn, .portbOut, .portbOe, .sysClkOutSrc, .readStrobeN,
		.writeStrobeHighN, .writeStrobeLowN, .chipSelN, .serialTx, .serialClockOut, .serialClockDrive,
		.timerExtClk, .extIntReqN, .dmaRequestN, .serialRx, .serialClockIn);
	// smallest variant beside the full one, same stimulus, only its port A enables compared
	pfs_port_select #(.SMALL_VARIANT(1'b1)) dutSmall (.ref_clk, .rst, .busAddr, .busWrData, .busWr, .busRd,
		.busRdData(), .modeStrap, .portaIn, .portaOut(), .portaOe(smallOe), .portbIn, .portbOut(), .portbOe(),
		.sysClkOutSrc, .readStrobeN, .writeStrobeHighN, .writeStrobeLowN, .chipSelN, .serialTx, .serialClockOut,
		.serialClockDrive, .timerExtClk(), .extIntReqN(), .dmaRequestN(), .serialRx(), .serialClockIn());
	pfs_pin_partner pads (.portaOut, .portaOe, .padA, .portbOut, .portbOe, .padB, .portaIn, .portbIn);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic close_out;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		busWr     <= 1'b1;
		busAddr   <= a;
		busWrData <= d;
		@(posedge ref_clk);
		busWr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		busRd   <= 1'b1;
		busAddr <= a;
		@(posedge ref_clk);
		busRd <= 1'b0;
		#1;
		chk("busRdData", exp, busRdData);
	endtask : rd

	task automatic do_reset(input logic [1:0] strap);
		@(posedge ref_clk);
		rst       <= 1'b1;
		modeStrap <= strap;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
	endtask : do_reset

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(PFS_ADDR_SEL1, 16'h0000);
		rd(PFS_ADDR_SEL2, 16'h0000);
		rd(PFS_ADDR_PB_DIR, 16'h0000);
		wr(PFS_ADDR_SEL2, 16'hFFFF);
		rd(PFS_ADDR_SEL2, 16'hFD75);
		wr(PFS_ADDR_PB_DIR, 16'hFFFF);
		rd(PFS_ADDR_PB_DIR, 16'h03FF);
		wr(PFS_ADDR_SEL1, 16'hFFFF);
		rd(PFS_ADDR_SEL1, 16'h555F);
		rd(32'hFFFF_8398, 16'h0000);
		settle(3);
		chk("portaOe", 16'h8000, portaOe & 16'hFC00);
		chk("portbOe", 16'h03FF, portbOe);
		wr(PFS_ADDR_PB_DATA, 16'hFD55);
		rd(PFS_ADDR_PB_DATA, 16'h0155);
		settle(1);
		chk("portbOut", 16'h0155, portbOut);
		wr(PFS_ADDR_SEL1, 16'h0000);
		wr(PFS_ADDR_SEL2, 16'h0000);
		// upper nibble driven from the latch, lower nibble read from the pads
		wr(PFS_ADDR_PA_DIR, 16'h00F0);
		wr(PFS_ADDR_PA_DATA, 16'h00A5);
		settle(3);
		chk("portaOe", 16'h00F0, portaOe);
		chk("portaOut", 16'h00A0, portaOut & 16'h00F0);
		rd(PFS_ADDR_PA_DATA, 16'h00A0);
		wr(PFS_ADDR_PA_DIR, 16'h0000);
	endtask : t_regs

	task automatic t_serial;
		padA     <= 16'h0000;
		serialTx <= 2'b10;
		wr(PFS_ADDR_SEL2, 16'h0145);
		settle(4);
		chk("portaOe", 16'h0012, portaOe & 16'h001F);
		chk("portaOut", 16'h0010, portaOut & 16'h0012);
		chk("serialRx", 16'h0000, serialRx);
		padA <= 16'h0009;
		settle(4);
		chk("serialRx", 16'h0003, serialRx);
		wr(PFS_ADDR_SEL2, 16'h0104);
		padA <= 16'h0000;
		settle(4);
		// deselected receive inputs idle high
		chk("serialRx", 16'h0003, serialRx);
	endtask : t_serial

	// codes 1 to 3 of the two-bit fields, single-chip mode
	task automatic t_fields;
		logic [3:0] tclk [3] = '{4'h5, 4'h0, 4'h0};
		logic [3:0] irq [3]  = '{4'hF, 4'h7, 4'hE};
		logic [1:0] sck [3]  = '{2'h2, 2'h0, 2'h0};
		logic [1:0] c;
		padA <= 16'h0160;
		for (int i = 0; i < 3; i++) begin
			c = 2'(i + 1);
			wr(PFS_ADDR_SEL1, {12'h000, c, c});
			wr(PFS_ADDR_SEL2, {c, c, c, 4'h0, c, 4'h0});
			settle(4);
			chk("timerExtClk", tclk[i], timerExtClk);
			chk("extIntReqN", irq[i], extIntReqN);
			chk("serialClockIn", sck[i], serialClockIn);
			chk("dmaRequestN", 16'h0003, dmaRequestN);
			chk("portaOe", 16'h0000, portaOe);
		end
	endtask : t_fields

	task automatic t_modes;
		sysClkOutSrc <= 1'b1;
		padA         <= 16'h0000;
		do_reset(2'h1);
		rd(PFS_ADDR_SEL1, 16'h4000);
		chk("pin15", 16'h0003, {portaOe[15], portaOut[15]});
		readStrobeN      <= 1'b0;
		writeStrobeHighN <= 1'b1;
		writeStrobeLowN  <= 1'b0;
		chipSelN         <= 4'hA;
		wr(PFS_ADDR_SEL1, 16'h1550);
		wr(PFS_ADDR_SEL2, 16'hA800);
		settle(4);
		chk("portaOe", 16'h7CC0, portaOe);
		chk("portaOut", 16'h2880, portaOut & 16'h7CC0);
		chk("dmaRequestN", 16'h0001, dmaRequestN);
		chk("smallOe", 16'h00C0, smallOe);
		do_reset(2'h2);
		rd(PFS_ADDR_SEL1, 16'h4000);
		chk("portaOe", 16'hFC00, portaOe);
		chk("smallOe", 16'h8000, smallOe);
	endtask : t_modes

	// ------------------------------------------------------------
	// main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		rst              = 1'b1;
		busWr            = 1'b0;
		busRd            = 1'b0;
		busAddr          = 32'h0000_0000;
		busWrData        = 16'h0000;
		modeStrap        = 2'h0;
		padA             = 16'h0000;
		padB             = 10'h000;
		sysClkOutSrc     = 1'b0;
		readStrobeN      = 1'b1;
		writeStrobeHighN = 1'b1;
		writeStrobeLowN  = 1'b1;
		chipSelN         = 4'hF;
		serialTx         = 2'h0;
		serialClockOut   = 2'h0;
		serialClockDrive = 2'h0;
		do_reset(2'h0);
		t_regs();
		t_serial();
		t_fields();
		t_modes();
		close_out();
	end

	initial begin
		#500000;
		n_mismatch++;
		close_out();
	end
endmodule : pfs_port_select_bench

// [pfs_port_select_checker.sv]
// concurrent checks on the port A/B pin function select top ports
// assumes rst is synchronous and active high on ref_clk

`timescale 1ns/1ps

module pfs_port_select_checker
	import pfs_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [31:0] busAddr,
	input wire logic [15:0] busWrData,
	input wire logic        busWr,
	input wire logic        busRd,
	input wire logic [15:0] busRdData,
	input wire logic [15:0] portaOut,
	input wire logic [15:0] portaOe,
	input wire logic [9:0]  portbOe,
	input wire logic [1:0]  serialTx,
	input wire logic [3:0]  extIntReqN,
	input wire logic [1:0]  dmaRequestN,
	input wire logic [1:0]  serialRx
);
	default clocking cb @(posedge ref_clk);
	endclocking

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence sRd(a);
		busRd && busAddr == a;
	endsequence
	// quiet cycle after the write so the pin flop sees the new select
	sequence sSel2Bit(n);
		busWr && busAddr == PFS_ADDR_SEL2 && busWrData[n] ##1 !(busWr && busAddr == PFS_ADDR_SEL2);
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_RD_IDLE: assert property (disable iff (rst) !busRd |=> busRdData == 16'h0000)
		else $error("read data not zero outside a read");
	AST_SEL2_RSVD: assert property (disable iff (rst) sRd(PFS_ADDR_SEL2) |=> (busRdData & 16'h028A) == 16'h0000)
		else $error("sel2 reserved bits read nonzero");
	AST_SEL1_ODD: assert property (disable iff (rst) sRd(PFS_ADDR_SEL1) |=> (busRdData & 16'hAAA0) == 16'h0000)
		else $error("sel1 odd bits read nonzero");
	AST_PB_RSVD: assert property (disable iff (rst) sRd(PFS_ADDR_PB_DIR) |=> busRdData[15:10] == 6'h00)
		else $error("port B direction upper bits nonzero");
	AST_PB_OE: assert property (disable iff (rst)
		busWr && busAddr == PFS_ADDR_PB_DIR ##1 !(busWr && busAddr == PFS_ADDR_PB_DIR)
		|=> portbOe == $past(busWrData[9:0], 2))
		else $error("port B enables do not follow direction write");
	AST_TX0: assert property (disable iff (rst) sSel2Bit(2) |=> portaOe[1] && portaOut[1] == $past(serialTx[0]))
		else $error("pin 1 not carrying serial 0 transmit");
	AST_TX1: assert property (disable iff (rst) sSel2Bit(8) |=> portaOe[4] && portaOut[4] == $past(serialTx[1]))
		else $error("pin 4 not carrying serial 1 transmit");
	AST_RX1_IN: assert property (disable iff (rst) sSel2Bit(6) |=> !portaOe[3])
		else $error("pin 3 driven while a receive input");
	AST_RESET_OUT: assert property (rst |=> portaOe == 16'h0000 && portbOe == 10'h000
		&& extIntReqN == 4'hF && dmaRequestN == 2'h3 && serialRx == 2'h3)
		else $error("outputs not at reset values during reset");
endmodule : pfs_port_select_checker

bind pfs_port_select pfs_port_select_checker uChecker (
	.ref_clk, .rst, .busAddr, .busWrData, .busWr, .busRd, .busRdData, .portaOut, .portaOe,
	.portbOe, .serialTx, .extIntReqN, .dmaRequestN, .serialRx
);

// [pfs_sel_if.sv]
// selection registers and decoded per-pin functions between top and decoder
// assumes both ends on ref_clk; purely combinational carrier

`timescale 1ns/1ps

interface pfs_sel_if;
	import pfs_pkg::*;
	logic      [15:0] sel1;
	logic      [15:0] sel2;
	pfs_mode_e        mode;
	pfs_func_e [15:0] func;

	modport decoder (input sel1, input sel2, input mode, output func);
	modport owner   (output sel1, output sel2, output mode, input func);
endinterface : pfs_sel_if
